// file: rtl/asm_params.svh
`ifndef ASM_PARAMS_SVH
`define ASM_PARAMS_SVH
`define ASM_ADDR_W 20
`define ASM_BANK_W 2
`define ASM_MASK_W 2
`define ASM_DATA_W 16
`define ASM_CS_W 3
`define ASM_CNT_W 7
`define ASM_UNIT_W 9
`define ASM_SUB_W 4
`define ASM_TA_MIN 3'h1
`define ASM_SETUP_MIN 5'h01
`define ASM_RST_MIN 7'h04
`define ASM_WST_MIN 7'h01
`define ASM_HOLD_MIN 4'h1
`define ASM_MAX_WAIT_LIMIT_MIN 9'h001
`define ASM_UNIT_LAST 4'hF
`define ASM_RELEASE_LOAD 7'h03
`endif

// file: rtl/asm_pkg.sv
`include "asm_params.svh"
package asm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE, ST_HOLD, ST_TURN
  } asm_state_type;
  typedef struct packed {
    asm_state_type st;
    logic [`ASM_CNT_W-1:0] cnt;
    logic [`ASM_SUB_W-1:0] sub;
    logic [`ASM_UNIT_W-1:0] units;
    logic waiting;
    logic waited;
    logic is_write;
    logic [`ASM_CS_W-1:0] sel;
    logic [`ASM_ADDR_W-1:0] addr;
    logic [`ASM_BANK_W-1:0] bank;
    logic [`ASM_MASK_W-1:0] mask;
    logic [`ASM_DATA_W-1:0] wdata;
    logic [`ASM_DATA_W-1:0] rdata;
    logic rd_valid;
    logic timeout;
    logic cs_act;
    logic oe_n;
    logic we_n;
    logic d_oe;
  } asm_state_reg_type;
endpackage : asm_pkg

// file: rtl/asm_strobe_sequencer.sv
// Function
// - read lasts setup+strobe+hold, plus sixteen cycles per wait unit if waiting
// - select-strobe off: chip select leads read strobe fall by read setup
// - select-strobe on: chip select follows the strobe exactly
// - read address, bank and mask valid read setup cycles before strobe falls
// - select-strobe off: select, address, bank, mask held read hold after strobe
// - read strobe low exactly read strobe cycles without extended waiting
// - with waiting, read strobe low grows sixteen cycles per wait unit
// - read strobe rises four to five cycles after wait released
// - wait lead time measured to unextended hold start
// - write lasts setup+strobe+hold, plus sixteen cycles per wait unit
// - write select leads strobe by write setup, or coincides with select-strobe
// - write data, address, bank, mask valid write setup before strobe falls
// - data, address, bank, mask held write hold after strobe rises; select too with select-strobe off
// - write strobe low write strobe cycles, extended per wait unit
// - write strobe rises four to five cycles after wait released
// - turnaround inserted between accesses; fields limited to documented ranges
// - waiting bounded by maximum wait limit, ending with a time-out
`include "asm_params.svh"
module asm_strobe_sequencer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`ASM_CS_W-1:0] req_select,
  input wire logic [`ASM_ADDR_W-1:0] req_addr,
  input wire logic [`ASM_BANK_W-1:0] req_bank,
  input wire logic [`ASM_MASK_W-1:0] req_mask,
  input wire logic [`ASM_DATA_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [`ASM_DATA_W-1:0] rd_data,
  output logic wait_timeout,
  input wire logic [2:0] turnaround_cycles,
  input wire logic [4:0] read_setup_cycles,
  input wire logic [6:0] read_strobe_cycles,
  input wire logic [3:0] read_hold_cycles,
  input wire logic [4:0] write_setup_cycles,
  input wire logic [6:0] write_strobe_cycles,
  input wire logic [3:0] write_hold_cycles,
  input wire logic extended_wait_enable,
  input wire logic select_strobe_enable,
  input wire logic [8:0] max_wait_limit,
  output logic [`ASM_CS_W-1:0] memory_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [`ASM_ADDR_W-1:0] memory_addr_lines,
  output logic [`ASM_BANK_W-1:0] bank_addr_lines,
  output logic [`ASM_MASK_W-1:0] byte_lane_mask,
  output logic [`ASM_DATA_W-1:0] memory_data_lines_o,
  output logic memory_data_lines_oe,
  input wire logic [`ASM_DATA_W-1:0] memory_data_lines_i,
  input wire logic memory_hold_off
);
  asm_pkg::asm_state_reg_type q, d;
  logic [2:0] ta_e;
  logic [4:0] rs_e, ws_e;
  logic [6:0] rst_e, wst_e;
  logic [3:0] rh_e, wh_e;
  logic [8:0] max_wait_limit_e;
  logic [4:0] su_e;
  logic [6:0] sb_e;
  logic [3:0] hd_e;

  // fields outside their range are pulled to the minimum
  assign ta_e = (turnaround_cycles < `ASM_TA_MIN) ? `ASM_TA_MIN : turnaround_cycles;
  assign rs_e = (read_setup_cycles < `ASM_SETUP_MIN) ? `ASM_SETUP_MIN : read_setup_cycles;
  assign ws_e = (write_setup_cycles < `ASM_SETUP_MIN) ? `ASM_SETUP_MIN : write_setup_cycles;
  assign rst_e = (read_strobe_cycles < `ASM_RST_MIN) ? `ASM_RST_MIN : read_strobe_cycles;
  assign wst_e = (write_strobe_cycles < `ASM_WST_MIN) ? `ASM_WST_MIN : write_strobe_cycles;
  assign rh_e = (read_hold_cycles < `ASM_HOLD_MIN) ? `ASM_HOLD_MIN : read_hold_cycles;
  assign wh_e = (write_hold_cycles < `ASM_HOLD_MIN) ? `ASM_HOLD_MIN : write_hold_cycles;
  assign max_wait_limit_e = (max_wait_limit < `ASM_MAX_WAIT_LIMIT_MIN) ? `ASM_MAX_WAIT_LIMIT_MIN : max_wait_limit;
  assign su_e = q.is_write ? ws_e : rs_e;
  assign sb_e = q.is_write ? wst_e : rst_e;
  assign hd_e = q.is_write ? wh_e : rh_e;

  assign req_ready = (q.st == asm_pkg::ST_IDLE);

  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    d.timeout = 1'b0;
    unique case (q.st)
      asm_pkg::ST_IDLE: begin
        if (req_valid) begin
          d.st = asm_pkg::ST_SETUP;
          d.is_write = req_write;
          d.sel = req_select;
          d.addr = req_addr;
          d.bank = req_bank;
          d.mask = req_mask;
          d.wdata = req_wdata;
          d.waited = 1'b0;
          d.cnt = req_write ? {2'h0, ws_e} - 7'h01 : {2'h0, rs_e} - 7'h01;
        end
      end
      asm_pkg::ST_SETUP: begin
        if (q.cnt == '0) begin
          d.st = asm_pkg::ST_STROBE;
          d.cnt = sb_e - 7'h01;
          d.sub = '0;
          d.units = '0;
          d.waiting = 1'b0;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      asm_pkg::ST_STROBE: begin
        if (q.waiting) begin
          // stretch in sixteen-cycle units while the memory holds off
          d.sub = q.sub + 4'h1;
          if (q.sub == `ASM_UNIT_LAST) begin
            d.units = q.units + 9'h001;
          end
          if (!memory_hold_off) begin
            d.st = asm_pkg::ST_RELEASE;
            d.cnt = `ASM_RELEASE_LOAD;
            d.waiting = 1'b0;
          end else if (q.sub == `ASM_UNIT_LAST && q.units + 9'h001 >= max_wait_limit_e) begin
            d.st = asm_pkg::ST_HOLD;
            d.cnt = {3'h0, hd_e} - 7'h01;
            d.waiting = 1'b0;
            d.timeout = 1'b1;
            d.rd_valid = !q.is_write;
            d.rdata = memory_data_lines_i;
          end
        end else if (extended_wait_enable && memory_hold_off) begin
          d.waiting = 1'b1;
          d.waited = 1'b1;
        end else if (q.cnt == '0) begin
          d.st = asm_pkg::ST_HOLD;
          d.cnt = {3'h0, hd_e} - 7'h01;
          d.rd_valid = !q.is_write;
          d.rdata = memory_data_lines_i;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      asm_pkg::ST_RELEASE: begin
        if (q.cnt == '0) begin
          d.st = asm_pkg::ST_HOLD;
          d.cnt = {3'h0, hd_e} - 7'h01;
          d.rd_valid = !q.is_write;
          d.rdata = memory_data_lines_i;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      asm_pkg::ST_HOLD: begin
        if (q.cnt == '0) begin
          d.st = asm_pkg::ST_TURN;
          d.cnt = {4'h0, ta_e} - 7'h01;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      asm_pkg::ST_TURN: begin
        if (q.cnt == '0) begin
          d.st = asm_pkg::ST_IDLE;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      default: d.st = asm_pkg::ST_IDLE;
    endcase
    // pin levels follow the next state so they leave flip-flops
    d.oe_n = !(!d.is_write && (d.st == asm_pkg::ST_STROBE || d.st == asm_pkg::ST_RELEASE));
    d.we_n = !(d.is_write && (d.st == asm_pkg::ST_STROBE || d.st == asm_pkg::ST_RELEASE));
    if (select_strobe_enable) begin
      d.cs_act = !(d.oe_n && d.we_n);
    end else begin
      d.cs_act = d.st inside {asm_pkg::ST_SETUP, asm_pkg::ST_STROBE,
                              asm_pkg::ST_RELEASE, asm_pkg::ST_HOLD};
    end
    d.d_oe = d.is_write && d.st inside {asm_pkg::ST_SETUP, asm_pkg::ST_STROBE,
                                        asm_pkg::ST_RELEASE, asm_pkg::ST_HOLD};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.st <= asm_pkg::ST_IDLE;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    memory_select_n = '1;
    if (q.cs_act) begin
      memory_select_n = ~q.sel;
    end
  end
  assign read_strobe_n = q.oe_n;
  assign write_strobe_n = q.we_n;
  assign memory_addr_lines = q.addr;
  assign bank_addr_lines = q.bank;
  assign byte_lane_mask = q.mask;
  assign memory_data_lines_o = q.wdata;
  assign memory_data_lines_oe = q.d_oe;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rdata;
  assign wait_timeout = q.timeout;

  // helper counters for the checks below
  logic [7:0] oe_len, we_len, cs_len, hold_len, ta_len;
  logic [9:0] acc_len;
  logic busy;
  assign busy = q.st inside {asm_pkg::ST_SETUP, asm_pkg::ST_STROBE,
                             asm_pkg::ST_RELEASE, asm_pkg::ST_HOLD};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_len <= '0;
      we_len <= '0;
      cs_len <= '0;
      hold_len <= '0;
      ta_len <= '0;
      acc_len <= '0;
    end else begin
      oe_len <= q.oe_n ? 8'h00 : oe_len + 8'h01;
      we_len <= q.we_n ? 8'h00 : we_len + 8'h01;
      cs_len <= q.cs_act ? cs_len + 8'h01 : 8'h00;
      hold_len <= (q.cs_act && q.oe_n && q.we_n) ? hold_len + 8'h01 : 8'h00;
      ta_len <= (q.st == asm_pkg::ST_TURN) ? ta_len + 8'h01 : 8'h00;
      acc_len <= busy ? acc_len + 10'h001 : 10'h000;
    end
  end

  property p_rd_strobe;
    @(posedge clock) disable iff (!nrst)
    $rose(read_strobe_n) && !q.waited |-> oe_len == {1'b0, rst_e};
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe width wrong");

  property p_wr_strobe;
    @(posedge clock) disable iff (!nrst)
    $rose(write_strobe_n) && !q.waited |-> we_len == {1'b0, wst_e};
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe width wrong");

  property p_setup_lead;
    @(posedge clock) disable iff (!nrst)
    !select_strobe_enable && ($fell(read_strobe_n) || $fell(write_strobe_n))
      |-> cs_len == {3'h0, su_e};
  endproperty
  a_setup_lead: assert property (p_setup_lead) else $error("select lead wrong");

  property p_sel_follows;
    @(posedge clock) disable iff (!nrst)
    select_strobe_enable && $past(select_strobe_enable)
      |-> (memory_select_n != '1) == !(read_strobe_n && write_strobe_n);
  endproperty
  a_sel_follows: assert property (p_sel_follows) else $error("select not on strobe");

  property p_hold_time;
    @(posedge clock) disable iff (!nrst)
    !select_strobe_enable && $fell(q.cs_act) |-> hold_len == {4'h0, hd_e};
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("hold time wrong");

  property p_lines_stable;
    @(posedge clock) disable iff (!nrst)
    busy && $past(busy) |-> $stable(memory_addr_lines) && $stable(bank_addr_lines)
      && $stable(byte_lane_mask) && $stable(memory_data_lines_o);
  endproperty
  a_lines_stable: assert property (p_lines_stable) else $error("lines moved");

  property p_cycle_len;
    @(posedge clock) disable iff (!nrst)
    q.st == asm_pkg::ST_HOLD && q.cnt == '0 && !q.waited
      |-> acc_len + 10'h001 == {5'h00, su_e} + {3'h0, sb_e} + {6'h00, hd_e};
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("access length wrong");

  property p_release;
    @(posedge clock) disable iff (!nrst)
    q.st == asm_pkg::ST_STROBE && q.waiting && !memory_hold_off
      |-> ##[4:5] (read_strobe_n && write_strobe_n);
  endproperty
  a_release: assert property (p_release) else $error("strobe late after wait");

  property p_turn;
    @(posedge clock) disable iff (!nrst)
    q.st == asm_pkg::ST_TURN && q.cnt == '0
      |-> ta_len + 8'h01 == {5'h00, ta_e};
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround wrong");

  property p_timeout;
    @(posedge clock) disable iff (!nrst)
    wait_timeout |-> $past(q.units) + 9'h001 >= max_wait_limit_e && q.st == asm_pkg::ST_HOLD;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout at wrong count");

  property p_capture;
    @(posedge clock) disable iff (!nrst)
    rd_valid |-> $rose(read_strobe_n);
  endproperty
  a_capture: assert property (p_capture) else $error("read data not at rise");

  property p_cov_read;
    @(posedge clock) disable iff (!nrst)
    $rose(read_strobe_n) ##1 q.st == asm_pkg::ST_HOLD;
  endproperty
  c_read: cover property (p_cov_read);

  property p_cov_write;
    @(posedge clock) disable iff (!nrst)
    $rose(write_strobe_n);
  endproperty
  c_write: cover property (p_cov_write);

  property p_cov_wait;
    @(posedge clock) disable iff (!nrst)
    q.waiting ##1 q.st == asm_pkg::ST_RELEASE;
  endproperty
  c_wait: cover property (p_cov_wait);

  property p_cov_timeout;
    @(posedge clock) disable iff (!nrst)
    wait_timeout;
  endproperty
  c_timeout: cover property (p_cov_timeout);
endmodule : asm_strobe_sequencer

// file: verif/asm_mem_model.sv
module asm_mem_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] memory_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [19:0] memory_addr_lines,
  input wire logic [15:0] memory_data_lines_o,
  input wire logic memory_data_lines_oe,
  input wire logic [7:0] wait_cycles,
  output logic [15:0] memory_data_lines_i,
  output logic memory_hold_off
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:15];
  logic [15:0] last_q;
  logic [7:0] left_q;
  logic idle_q;
  logic rd_on;
  assign rd_on = !read_strobe_n && (memory_select_n != 3'h7);
  // released bus shows the inverse of its last value
  assign memory_data_lines_i = rd_on ? mem[memory_addr_lines[3:0]] : ~last_q;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_q <= 16'h0000;
      left_q <= 8'h00;
      idle_q <= 1'b1;
      memory_hold_off <= 1'b0;
    end else begin
      last_q <= memory_data_lines_i;
      idle_q <= read_strobe_n & write_strobe_n;
      if (!write_strobe_n && memory_data_lines_oe) mem[memory_addr_lines[3:0]] <= memory_data_lines_o;
      // wait raised one cycle after strobe falls, well before its end
      if (idle_q && !(read_strobe_n & write_strobe_n) && wait_cycles != 8'h00) begin
        memory_hold_off <= 1'b1;
        left_q <= wait_cycles;
      end else if (left_q > 8'h01) begin
        left_q <= left_q - 8'h01;
      end else begin
        memory_hold_off <= 1'b0;
        left_q <= 8'h00;
      end
    end
  end
endmodule : asm_mem_model

// file: verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_select = 3'h1;
  logic [19:0] req_addr = 20'h00000;
  logic [1:0] req_bank = 2'h0;
  logic [1:0] req_mask = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic [2:0] ta = 3'h1;
  logic [4:0] rs = 5'h01;
  logic [4:0] ws = 5'h01;
  logic [6:0] rb = 7'h04;
  logic [6:0] wb = 7'h01;
  logic [3:0] rh = 4'h1;
  logic [3:0] wh = 4'h1;
  logic ew = 1'b0;
  logic ss = 1'b0;
  logic [8:0] mwl = 9'h100;
  logic [7:0] wcy = 8'h00;
  logic req_ready, rd_valid, wait_timeout, rsn, wsn, doe, hold;
  logic [15:0] rd_data, d_o, d_i;
  logic [2:0] sel_n;
  logic [19:0] addr;
  logic [1:0] bank, mask;
  int n_fail = 0;
  int compares = 0;
  int last_wt, last_rv;
  int cs[4] = '{0, 1, 3, 16};
  int cb[4] = '{0, 4, 6, 64};
  int ch[4] = '{0, 1, 2, 8};
  int ct[4] = '{0, 1, 4, 2};
  always #50 clock = ~clock;
  asm_strobe_sequencer u_dut (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_select(req_select), .req_addr(req_addr),
    .req_bank(req_bank), .req_mask(req_mask), .req_wdata(req_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .wait_timeout(wait_timeout), .turnaround_cycles(ta),
    .read_setup_cycles(rs), .read_strobe_cycles(rb), .read_hold_cycles(rh),
    .write_setup_cycles(ws), .write_strobe_cycles(wb), .write_hold_cycles(wh),
    .extended_wait_enable(ew), .select_strobe_enable(ss), .max_wait_limit(mwl),
    .memory_select_n(sel_n), .read_strobe_n(rsn), .write_strobe_n(wsn),
    .memory_addr_lines(addr), .bank_addr_lines(bank), .byte_lane_mask(mask),
    .memory_data_lines_o(d_o), .memory_data_lines_oe(doe), .memory_data_lines_i(d_i),
    .memory_hold_off(hold));
  asm_mem_model u_mem (.clock(clock), .nrst(nrst), .memory_select_n(sel_n),
    .read_strobe_n(rsn), .write_strobe_n(wsn), .memory_addr_lines(addr),
    .memory_data_lines_o(d_o), .memory_data_lines_oe(doe), .wait_cycles(wcy),
    .memory_data_lines_i(d_i), .memory_hold_off(hold));
  task final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task access(input logic w, input logic [19:0] a, input logic [15:0] d,
              input int s, input int b, input int h, input int t, input bit tm);
    int k, ph, nset, nstr, nhld, nbusy, bad, rel, rv, wt;
    bit seen;
    logic st, on;
    {ph, nset, nstr, nhld, nbusy, bad, rel, rv, wt, seen} = '0;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    for (k = 0; k < 3000 && !(k > 0 && req_ready === 1'b1); k++) begin
      st = w ? wsn : rsn;
      on = sel_n !== 3'h7;
      if (on && (sel_n !== ~req_select || addr !== a || bank !== req_bank)) bad++;
      if (on && mask !== req_mask) bad++;
      if (w && on && (doe !== 1'b1 || d_o !== d)) bad++;
      if (!w && doe !== 1'b0) bad++;
      if ((w ? rsn : wsn) !== 1'b1) bad++;
      if (st === 1'b0) begin
        ph = 1;
        nstr++;
        if (hold === 1'b1) seen = 1;
        else if (seen) rel++;
      end else if (ph == 0 && on) nset++;
      else if (ph > 0) begin
        ph = 2;
        if (on) nhld++;
      end
      if (req_ready !== 1'b1) nbusy++;
      if (rd_valid === 1'b1) rv++;
      if (wait_timeout === 1'b1) wt++;
      if (!w && rd_valid === 1'b1) `CHK(rd_data, d);
      @(negedge clock);
    end
    if (k == 3000) begin
      n_fail++;
      final_report();
    end
    last_wt = wt;
    last_rv = rv;
    `CHK(bad, 0);
    `CHK(rv, w ? 0 : 1);
    if (ew && seen && wt == 0) `CHK(rel >= 4 && rel <= 5, 1'b1);
    if (tm) begin
      `CHK(nset, ss ? 0 : s);
      `CHK(nstr, b);
      `CHK(nhld, ss ? 0 : h);
      `CHK(nbusy, s + b + h + t);
      `CHK(wt, 0);
    end
  endtask : access
  function automatic int mx(input int v, input int m);
    return v < m ? m : v;
  endfunction : mx
  initial begin
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      {rs, ws} = {5'(cs[i]), 5'(cs[i])};
      {rb, wb} = {7'(cb[i]), 7'(cb[i])};
      {rh, wh, ta} = {4'(ch[i]), 4'(ch[i]), 3'(ct[i])};
      req_select = 3'h1 << (i % 3);
      req_bank = 2'(i);
      req_mask = ~2'(i);
      access(1'b1, 20'h5A5A0 + 20'(i), 16'hC3A0 + 16'(i), mx(cs[i], 1), mx(cb[i], 1),
             mx(ch[i], 1), mx(ct[i], 1), 1'b1);
      access(1'b0, 20'h5A5A0 + 20'(i), 16'hC3A0 + 16'(i), mx(cs[i], 1), mx(cb[i], 4),
             mx(ch[i], 1), mx(ct[i], 1), 1'b1);
    end
    $display("test phase timing done");
    {rs, ws, rb, wb, rh, wh, ta} = {5'h03, 5'h03, 7'h06, 7'h06, 4'h2, 4'h2, 3'h1};
    ss = 1'b1;
    access(1'b1, 20'h00007, 16'hBEEF, 3, 6, 2, 1, 1'b1);
    access(1'b0, 20'h00007, 16'hBEEF, 3, 6, 2, 1, 1'b1);
    ss = 1'b0;
    $display("test select strobe done");
    {rb, wb, wcy} = {7'h08, 7'h08, 8'h03};
    access(1'b0, 20'h00007, 16'hBEEF, 3, 8, 2, 1, 1'b1);
    ew = 1'b1;
    access(1'b1, 20'h00009, 16'h1234, 3, 8, 2, 1, 1'b0);
    access(1'b0, 20'h00009, 16'h1234, 3, 8, 2, 1, 1'b0);
    $display("test extended wait done");
    {mwl, wcy} = {9'h001, 8'h3C};
    access(1'b0, 20'h00009, 16'h1234, 3, 8, 2, 1, 1'b0);
    `CHK(last_wt, 1);
    `CHK(last_rv, 1);
    repeat (60) @(negedge clock);
    $display("test wait time-out done");
    final_report();
  end
endmodule : tb
